/* hdl/ffrs_pkg.sv */
/*
 * Package for the fast function and range select decoder: function codes,
 * range codes, command opcodes, error codes and default settings.
 * Assumes the command parser upstream delivers one decoded code per strobe.
 */
package ffrs_pkg;

	// Measurement functions reached by the short codes
	typedef enum logic [1:0] {
		FN_DC_VOLTS = 2'b00,
		FN_DC_AMPS = 2'b01,
		FN_TWO_WIRE_OHMS = 2'b10,
		FN_FOUR_WIRE_OHMS = 2'b11
	} ffrs_func_t;

	// Command kinds presented on the command port
	typedef enum logic [2:0] {
		CMD_FUNCTION = 3'b000,
		CMD_RANGE = 3'b001,
		CMD_RESET = 3'b010,
		CMD_SET_INTEGRATION_LINE_CYCLES = 3'b011,
		CMD_OTHER_FUNC = 3'b100
	} ffrs_cmd_t;

	// Error codes reported on a rejected command
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_INVALID_RANGE = 2'h1;
	localparam logic [1:0] ERR_OUT_OF_RANGE = 2'h2;
	localparam logic [1:0] ERR_NOT_SUPPORTED = 2'h3;

	// Range codes, one to seven; zero is never a legal code
	localparam logic [2:0] RANGE_CODE_ONE = 3'h1;
	localparam logic [2:0] RANGE_CODE_TWO = 3'h2;
	localparam logic [2:0] RANGE_CODE_THREE = 3'h3;
	localparam logic [2:0] RANGE_CODE_FOUR = 3'h4;
	localparam logic [2:0] RANGE_CODE_FIVE = 3'h5;
	localparam logic [2:0] RANGE_CODE_SEVEN = 3'h7;

	// Highest legal code per function
	localparam logic [2:0] DCV_MAX_RANGE = RANGE_CODE_FIVE;
	localparam logic [2:0] DCI_MAX_RANGE = RANGE_CODE_FOUR;
	localparam logic [2:0] OHMS_MAX_RANGE = RANGE_CODE_SEVEN;

	// Power-on and reset-command defaults
	localparam logic [2:0] DCV_POWER_ON_RANGE = RANGE_CODE_THREE;
	localparam logic [2:0] DCV_RESET_RANGE = RANGE_CODE_FIVE;
	localparam logic [2:0] DCI_DEFAULT_RANGE = RANGE_CODE_THREE;
	localparam logic [2:0] OHMS_DEFAULT_RANGE = RANGE_CODE_TWO;
	localparam logic [7:0] INTEGRATION_LINE_CYCLES_DEFAULT = 8'h0A;
	localparam ffrs_func_t FUNC_DEFAULT = FN_DC_VOLTS;

endpackage

/* hdl/ffrs_setting.sv */
/*
 * One function's remembered range and integration setting.
 * Assumes the decoder upstream has already checked the range code.
 */
`timescale 1ns/100ps
module ffrs_setting #(
	parameter logic [2:0] POWER_ON_RANGE = 3'h1,
	parameter logic [2:0] RESET_RANGE = 3'h1
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_reset_cmd,
	input wire logic i_range_we,
	input wire logic [2:0] i_range,
	input wire logic i_integration_line_cycles_we,
	input wire logic [7:0] i_integration_line_cycles,
	output logic [2:0] o_range,
	output logic [7:0] o_integration_line_cycles
);

	logic [2:0] range_r;
	logic [2:0] range_nxt;
	logic [7:0] integration_line_cycles_r;
	logic [7:0] integration_line_cycles_nxt;

	// Reset command wins over a write arriving in the same cycle
	always_comb begin
		range_nxt = range_r;
		integration_line_cycles_nxt = integration_line_cycles_r;
		if (i_reset_cmd) begin
			range_nxt = RESET_RANGE;
			integration_line_cycles_nxt = ffrs_pkg::INTEGRATION_LINE_CYCLES_DEFAULT;
		end else begin
			if (i_range_we) begin
				range_nxt = i_range;
			end
			// Only the dedicated command touches the integration setting
			if (i_integration_line_cycles_we) begin
				integration_line_cycles_nxt = i_integration_line_cycles;
			end
		end
	end

	// State is per function, so it survives switching away
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			range_r <= POWER_ON_RANGE;
			integration_line_cycles_r <= ffrs_pkg::INTEGRATION_LINE_CYCLES_DEFAULT;
		end else begin
			range_r <= range_nxt;
			integration_line_cycles_r <= integration_line_cycles_nxt;
		end
	end

	assign o_range = range_r;
	assign o_integration_line_cycles = integration_line_cycles_r;

endmodule

/* hdl/ffrs_decoder.sv */
/*
 * Fast function and range select decoder. Takes one decoded short code per
 * strobe and keeps current function plus per-function range and settings.
 * Assumes commands arrive synchronous to i_clock from the parser.
 */
// Summary of operation
// - Four codes select DC_VOLTS_FUNCTION, DC_AMPS_FUNCTION, 2W, 4W ohms
// - AC, frequency, period not reachable by short codes
// - DC_VOLTS_FUNCTION ranges one-five, DC_AMPS_FUNCTION one-four, else error
// - Ohms ranges one to seven, both kinds
// - Short codes act like standard sense commands
// - Range code changes current function only, or both ohms kinds together
// - Reselected function restores its last range
// - Ohms range change applies to both ohms
// - Power-on and reset-command default settings
// - Short codes never alter integration setting
`timescale 1ns/100ps
module ffrs_decoder (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_cmd_valid,
	input wire logic [2:0] i_cmd,
	input wire logic [2:0] i_cmd_arg,
	input wire logic [7:0] i_integration_line_cycles,
	output logic [1:0] o_function,
	output logic [2:0] o_range,
	output logic [7:0] o_integration_line_cycles,
	output logic o_done,
	output logic o_error,
	output logic [1:0] o_error_code
);

	logic rst_sync1_r;
	logic rst_sync2_r;
	logic rst_n;

	// Reset released through two flops so no flop sees a ragged release;
	// only the second flop is read, the first may still be settling
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end
	assign rst_n = rst_sync2_r;

	// Current function and the registered outputs
	ffrs_pkg::ffrs_func_t func_r;
	ffrs_pkg::ffrs_func_t func_nxt;
	ffrs_pkg::ffrs_cmd_t cmd;
	logic done_r;
	logic done_nxt;
	logic error_r;
	logic error_nxt;
	logic [1:0] err_code_r;
	logic [1:0] err_code_nxt;
	logic [2:0] range_r;
	logic [2:0] range_nxt;
	logic [7:0] integration_line_cycles_r;
	logic [7:0] integration_line_cycles_nxt;
	// Range check and decoded strobes
	logic [2:0] max_range;
	logic range_ok;
	logic is_range;
	logic reset_cmd;
	logic integration_line_cycles_cmd;
	// Per-function write enables and stored settings
	logic [3:0] range_we;
	logic [3:0] integration_line_cycles_we;
	logic [2:0] fn_range [4];
	logic [7:0] fn_integration_line_cycles [4];

	// Codes five to seven fall outside the enum and reach the default arm
	assign cmd = ffrs_pkg::ffrs_cmd_t'(i_cmd);

	// Highest legal range code for the function now selected
	always_comb begin
		unique case (func_r)
			ffrs_pkg::FN_DC_VOLTS: max_range = ffrs_pkg::DCV_MAX_RANGE;
			ffrs_pkg::FN_DC_AMPS: max_range = ffrs_pkg::DCI_MAX_RANGE;
			ffrs_pkg::FN_TWO_WIRE_OHMS,
			ffrs_pkg::FN_FOUR_WIRE_OHMS: max_range = ffrs_pkg::OHMS_MAX_RANGE;
		endcase
	end

	// Code zero is never legal; upper limit depends on function
	assign range_ok = (i_cmd_arg >= ffrs_pkg::RANGE_CODE_ONE) &&
		(i_cmd_arg <= max_range);
	assign is_range = i_cmd_valid && (cmd == ffrs_pkg::CMD_RANGE);
	assign reset_cmd = i_cmd_valid && (cmd == ffrs_pkg::CMD_RESET);
	assign integration_line_cycles_cmd = i_cmd_valid && (cmd == ffrs_pkg::CMD_SET_INTEGRATION_LINE_CYCLES);

	// Per-function write enables; the two ohms functions share ranges
	always_comb begin
		range_we = 4'h0;
		integration_line_cycles_we = 4'h0;
		if (is_range && range_ok) begin
			range_we[func_r] = 1'b1;
			// Both ohms kinds share one range, whichever is selected
			if (func_r == ffrs_pkg::FN_TWO_WIRE_OHMS ||
				func_r == ffrs_pkg::FN_FOUR_WIRE_OHMS) begin
				range_we[ffrs_pkg::FN_TWO_WIRE_OHMS] = 1'b1;
				range_we[ffrs_pkg::FN_FOUR_WIRE_OHMS] = 1'b1;
			end
		end
		if (integration_line_cycles_cmd) begin
			integration_line_cycles_we[func_r] = 1'b1;
		end
	end

	// One settings store per function, each with its own defaults
	for (genvar g = 0; g < 4; g++) begin : g_fn
		localparam logic [2:0] PON = (g == 0) ?
			ffrs_pkg::DCV_POWER_ON_RANGE : (g == 1) ?
			ffrs_pkg::DCI_DEFAULT_RANGE : ffrs_pkg::OHMS_DEFAULT_RANGE;
		localparam logic [2:0] RST = (g == 0) ?
			ffrs_pkg::DCV_RESET_RANGE : PON;
		ffrs_setting #(
			.POWER_ON_RANGE(PON),
			.RESET_RANGE(RST)
		) u_setting (
			.i_clock(i_clock),
			.i_rst_n(rst_n),
			.i_reset_cmd(reset_cmd),
			.i_range_we(range_we[g]),
			.i_range(i_cmd_arg),
			.i_integration_line_cycles_we(integration_line_cycles_we[g]),
			.i_integration_line_cycles(i_integration_line_cycles),
			.o_range(fn_range[g]),
			.o_integration_line_cycles(fn_integration_line_cycles[g])
		);
	end

	// Command decode: function select, range, reset, and rejections
	always_comb begin
		func_nxt = func_r;
		done_nxt = 1'b0;
		error_nxt = 1'b0;
		err_code_nxt = ffrs_pkg::ERR_NONE;
		if (i_cmd_valid) begin
			done_nxt = 1'b1;
			unique case (cmd)
				ffrs_pkg::CMD_FUNCTION: begin
					func_nxt = ffrs_pkg::ffrs_func_t'(i_cmd_arg[1:0]);
					// Four and up would be AC or counter kinds,
					// which the short codes never reach
					if (i_cmd_arg[2]) begin
						func_nxt = func_r;
						error_nxt = 1'b1;
						err_code_nxt = ffrs_pkg::ERR_NOT_SUPPORTED;
					end
				end
				ffrs_pkg::CMD_RANGE: begin
					if (!range_ok) begin
						error_nxt = 1'b1;
						err_code_nxt = (func_r == ffrs_pkg::FN_DC_AMPS) ?
							ffrs_pkg::ERR_OUT_OF_RANGE :
							ffrs_pkg::ERR_INVALID_RANGE;
					end
				end
				ffrs_pkg::CMD_RESET: begin
					func_nxt = ffrs_pkg::FUNC_DEFAULT;
				end
				ffrs_pkg::CMD_SET_INTEGRATION_LINE_CYCLES: begin
					func_nxt = func_r;
				end
				ffrs_pkg::CMD_OTHER_FUNC: begin
					error_nxt = 1'b1;
					err_code_nxt = ffrs_pkg::ERR_NOT_SUPPORTED;
				end
				// Unused codes are refused, never dropped
				default: begin
					error_nxt = 1'b1;
					err_code_nxt = ffrs_pkg::ERR_NOT_SUPPORTED;
				end
			endcase
		end
	end

	// Outputs show the settings the stores will hold after this edge.
	// Looking ahead costs a mux per output but keeps them in step
	// with o_done, so a done never stands beside a stale range.
	always_comb begin
		range_nxt = fn_range[func_nxt];
		integration_line_cycles_nxt = fn_integration_line_cycles[func_nxt];
		if (reset_cmd) begin
			range_nxt = ffrs_pkg::DCV_RESET_RANGE;
			integration_line_cycles_nxt = ffrs_pkg::INTEGRATION_LINE_CYCLES_DEFAULT;
		end else if (integration_line_cycles_cmd) begin
			integration_line_cycles_nxt = i_integration_line_cycles;
		end else if (is_range && range_ok) begin
			range_nxt = i_cmd_arg;
		end
	end

	// Outputs registered so they come straight from flops
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			func_r <= ffrs_pkg::FUNC_DEFAULT;
			range_r <= ffrs_pkg::DCV_POWER_ON_RANGE;
			integration_line_cycles_r <= ffrs_pkg::INTEGRATION_LINE_CYCLES_DEFAULT;
			done_r <= 1'b0;
			error_r <= 1'b0;
			err_code_r <= ffrs_pkg::ERR_NONE;
		end else begin
			func_r <= func_nxt;
			range_r <= range_nxt;
			integration_line_cycles_r <= integration_line_cycles_nxt;
			done_r <= done_nxt;
			error_r <= error_nxt;
			err_code_r <= err_code_nxt;
		end
	end

	// Ports are plain copies of the output flops
	assign o_function = func_r;
	assign o_range = range_r;
	assign o_integration_line_cycles = integration_line_cycles_r;
	assign o_done = done_r;
	assign o_error = error_r;
	assign o_error_code = err_code_r;

endmodule

/* verif/ffrs_decoder_sva.sv */
/* Port checker for the short-code decoder.
 Assumes one clock and the async active-low reset. */
`timescale 1ns/100ps
module ffrs_decoder_sva (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic i_cmd_valid,
	input wire logic [2:0] i_cmd,
	input wire logic [2:0] i_cmd_arg,
	input wire logic [1:0] o_function,
	input wire logic [2:0] o_range,
	input wire logic [7:0] o_integration_line_cycles,
	input wire logic o_done,
	input wire logic o_error,
	input wire logic [1:0] o_error_code
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// Strobes by kind
	sequence s_fn;
		i_cmd_valid && i_cmd == ffrs_pkg::CMD_FUNCTION;
	endsequence
	sequence s_rng;
		i_cmd_valid && i_cmd == ffrs_pkg::CMD_RANGE;
	endsequence
	done_once_a: assert property (i_cmd_valid |=> o_done)
		else $error("no done after strobe");
	done_idle_a: assert property (
		!i_cmd_valid |=> !o_done && !o_error)
		else $error("done without strobe");
	func_pick_a: assert property (
		s_fn ##0 !i_cmd_arg[2] |=>
		o_function == $past(i_cmd_arg[1:0]) && !o_error)
		else $error("function not taken");
	func_other_a: assert property (
		i_cmd_valid && i_cmd == ffrs_pkg::CMD_OTHER_FUNC |=>
		o_error && o_error_code == 2'h3 && $stable(o_function))
		else $error("other function not refused");
	dcv_range_a: assert property (
		s_rng ##0 (o_function == 2'h0 && i_cmd_arg inside {[1:5]})
		|=> o_range == $past(i_cmd_arg) && !o_error)
		else $error("volts range wrong");
	dci_over_a: assert property (
		s_rng ##0 (o_function == 2'h1 && i_cmd_arg > 3'h4) |=>
		o_error_code == 2'h2 && $stable(o_range))
		else $error("amps over range not refused");
	ohms_range_a: assert property (
		s_rng ##0 (o_function[1] && i_cmd_arg != 3'h0) |=>
		o_range == $past(i_cmd_arg) && !o_error)
		else $error("ohms range wrong");
	bad_keep_a: assert property (
		s_rng ##0 (o_function == 2'h0 && !(i_cmd_arg inside {[1:5]}))
		|=> o_error && o_error_code == 2'h1 && $stable(o_range))
		else $error("bad range not refused");
	integration_line_cycles_keep_a: assert property (s_rng |=> $stable(o_integration_line_cycles))
		else $error("range code moved integration_line_cycles");
	reset_dflt_a: assert property (
		$rose(i_nrst) |-> o_function == 2'h0 &&
		o_range == 3'h3 && o_integration_line_cycles == 8'h0A)
		else $error("power-on state wrong");
endmodule
bind ffrs_decoder ffrs_decoder_sva u_sva (.*);

/* verif/ffrs_host.sv */
/* Host model issuing one short code per strobe.
 Assumes calls start just after a clock edge. */
`timescale 1ns/100ps
module ffrs_host (
	input wire logic i_clock,
	output logic o_cmd_valid,
	output logic [2:0] o_cmd,
	output logic [2:0] o_arg,
	output logic [7:0] o_integration_line_cycles
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = 3'h0;
		o_arg = 3'h0;
		o_integration_line_cycles = 8'h00;
	end
	// Strobe holds until the next call, so codes can go back to back
	task send(input logic [2:0] c, a, input logic [7:0] n);
		@(posedge i_clock);
		o_cmd_valid <= 1'b1;
		o_cmd <= c;
		o_arg <= a;
		o_integration_line_cycles <= n;
	endtask
	// Unqualified lines carry junk so stale values never help
	task idle();
		@(posedge i_clock);
		o_cmd_valid <= 1'b0;
		o_cmd <= ~o_cmd;
		o_arg <= ~o_arg;
		o_integration_line_cycles <= ~o_integration_line_cycles;
	endtask
endmodule

/* verif/test_fast_function_range_select.sv */
/* Testbench for the short-code decoder, directed and random.
 Assumes the host model drives the command port. */
`timescale 1ns/100ps
module test_fast_function_range_select;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic v;
	logic [2:0] c;
	logic [2:0] a;
	logic [7:0] n;
	logic [1:0] o_fn;
	logic [1:0] o_ec;
	logic [2:0] o_rg;
	logic [7:0] o_np;
	logic o_done;
	logic o_err;
	logic [15:0] q[$];
	logic [1:0] fn;
	logic [2:0] rg[4];
	logic [7:0] np[4];
	logic [15:0] seed = 16'h0050;
	int err_count = 0;
	int checks_done = 0;
	always #25 i_clock = ~i_clock;
	ffrs_host host (.i_clock(i_clock), .o_cmd_valid(v), .o_cmd(c),
		.o_arg(a), .o_integration_line_cycles(n));
	ffrs_decoder uut (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_cmd_valid(v), .i_cmd(c), .i_cmd_arg(a), .i_integration_line_cycles(n),
		.o_function(o_fn), .o_range(o_rg), .o_integration_line_cycles(o_np),
		.o_done(o_done), .o_error(o_err), .o_error_code(o_ec));
	function automatic logic [15:0] xs(input logic [15:0] x);
		x = x ^ (x << 7);
		x = x ^ (x >> 9);
		return x ^ (x << 8);
	endfunction
	task check(input string nm, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Model state after power-on or the reset command
	task dflt(input logic [2:0] dc_volts_function);
		fn = 2'h0;
		rg = '{dc_volts_function, 3'h3, 3'h2, 3'h2};
		np = '{4{8'h0A}};
	endtask
	// Note the expected answer, then hand the code to the host
	task run(input logic [2:0] k, r, input logic [7:0] p);
		logic [1:0] ec;
		logic [2:0] mx;
		ec = 2'h0;
		mx = fn == 2'h0 ? 3'h5 : fn == 2'h1 ? 3'h4 : 3'h7;
		case (k)
		3'h0: begin
			if (r[2]) ec = 2'h3;
			else fn = r[1:0];
		end
		3'h1: begin
			if (r == 3'h0 || r > mx) ec = fn == 2'h1 ? 2'h2 : 2'h1;
			else begin
				rg[fn] = r;
				if (fn[1]) rg[fn ^ 2'h1] = r;
			end
		end
		3'h2: dflt(3'h5);
		3'h3: np[fn] = p;
		default: ec = 2'h3;
		endcase
		q.push_back({|ec, ec, fn, rg[fn], np[fn]});
		host.send(k, r, p);
	endtask
	// Each completion takes the oldest note
	always @(negedge i_clock) begin
		if (o_done === 1'b1)
			check("result", q.size() ? q.pop_front() : 16'hXXXX,
				{o_err, o_ec, o_fn, o_rg, o_np});
	end
	task results();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		dflt(3'h3);
		repeat (12) @(posedge i_clock);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clock);
		for (int i = 1; i < 5; i++) run(3'h0, 3'(i & 3), 8'h00);
		run(3'h0, 3'h2, 8'h00);
		run(3'h1, 3'h7, 8'h00);
		run(3'h0, 3'h3, 8'h00);
		run(3'h1, 3'h0, 8'h00);
		run(3'h0, 3'h1, 8'h00);
		run(3'h1, 3'h5, 8'h00);
		run(3'h0, 3'h0, 8'h00);
		run(3'h1, 3'h6, 8'h00);
		run(3'h3, 3'h0, 8'h21);
		run(3'h1, 3'h1, 8'h00);
		run(3'h4, 3'h0, 8'h00);
		run(3'h2, 3'h0, 8'h00);
		// Random codes back to back, refused kinds included
		repeat (300) begin
			seed = xs(seed);
			run(seed[2:0], seed[5:3], seed[15:8]);
		end
		repeat (3) host.idle();
		i_nrst <= 1'b0;
		dflt(3'h3);
		repeat (12) host.idle();
		i_nrst <= 1'b1;
		repeat (2) host.idle();
		run(3'h1, 3'h1, 8'h00);
		run(3'h0, 3'h3, 8'h00);
		host.idle();
		for (int k = 0; k < 10 && q.size() > 0; k++) @(posedge i_clock);
		if (q.size() > 0) check("drain", 16'h0000, 16'hFFFF);
		results();
	end
endmodule
